// ===== logic/disc_pkg.sv
package disc_pkg;

  // ****************************************
  // Register offsets (fieldbus parameter addresses)
  // ****************************************
  localparam logic [15:0] OFS_CTRL_SRC = 16'h0502;
  localparam logic [15:0] OFS_POS_FN = 16'h0504;
  localparam logic [15:0] OFS_START_MODE = 16'h0506;
  localparam logic [15:0] OFS_NODE = 16'h1704;
  localparam logic [15:0] OFS_BAUD = 16'h1706;
  localparam logic [15:0] OFS_MOTOR_BASE = 16'h3000;
  localparam logic [15:0] OFS_STATUS = 16'h3010;

  // ****************************************
  // Setting slots and reset values
  // ****************************************
  localparam int NUM_CFG = 5;
  localparam logic [2:0] SLOT_CTRL_SRC = 3'h0;
  localparam logic [2:0] SLOT_POS_FN = 3'h1;
  localparam logic [2:0] SLOT_START_MODE = 3'h2;
  localparam logic [2:0] SLOT_NODE = 3'h3;
  localparam logic [2:0] SLOT_BAUD = 3'h4;
  localparam logic [15:0] RST_CTRL_SRC = 16'h0000;
  localparam logic [15:0] RST_POS_FN = 16'h0000;
  localparam logic [15:0] RST_START_MODE = 16'h0000;
  localparam logic [15:0] RST_NODE = 16'h007F;
  localparam logic [15:0] RST_BAUD = 16'h007D;

  // ****************************************
  // Value encodings and limits
  // ****************************************
  localparam logic [15:0] SRC_UNDEFINED = 16'h0000;
  localparam logic [15:0] SRC_LOCAL_IO = 16'h0001;
  localparam logic [15:0] SRC_CAN_FIELDBUS = 16'h0002;
  localparam logic [15:0] SRC_SERIAL_FIELDBUS = 16'h0003;
  localparam logic [15:0] POS_FN_MAX = 16'h0002;
  localparam logic [15:0] MODE_NONE = 16'h0000;
  localparam logic [15:0] MODE_TORQUE_LOOP = 16'h0001;
  localparam logic [15:0] MODE_VELOCITY_LOOP = 16'h0002;
  localparam logic [15:0] MODE_GEAR_FOLLOW = 16'h0003;
  localparam logic [15:0] MODE_UNDEFINED = 16'h0004;
  localparam logic [15:0] MODE_JOG = 16'h0005;
  localparam logic [15:0] MODE_SEQUENCED_MOTION = 16'h0006;
  localparam logic [15:0] NODE_MIN = 16'h0001;
  localparam logic [15:0] NODE_MAX = 16'h007F;
  localparam logic [15:0] BAUD_50K = 16'h0032;
  localparam logic [15:0] BAUD_125K = 16'h007D;
  localparam logic [15:0] BAUD_250K = 16'h00FA;
  localparam logic [15:0] BAUD_500K = 16'h01F4;
  localparam logic [15:0] BAUD_1000K = 16'h03E8;

  // ****************************************
  // Motor data set and nonvolatile map
  // ****************************************
  localparam int MOTOR_WORDS = 8;
  localparam logic [3:0] NVM_LAST_LOAD = 4'hF;
  localparam logic [3:0] NVM_VALID_SLOT = 4'h5;
  localparam logic [3:0] NVM_MOTOR_BASE = 4'h8;
  // Seal value is arbitrary; it only marks a completed motor data store
  localparam logic [15:0] NVM_SEAL = 16'hA5C3;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_CHECK = 3'b001,
    ST_FETCH = 3'b010,
    ST_STORE = 3'b011,
    ST_SEAL = 3'b100,
    ST_IDLE = 3'b101,
    ST_SAVE = 3'b110
  } disc_state_t;

  typedef struct packed {
    logic [15:0] ctrl_src;
    logic [15:0] pos_fn;
    logic [15:0] start_mode;
    logic [15:0] node;
    logic [15:0] baud;
  } disc_cfg_t;

endpackage : disc_pkg

// ===== logic/disc_config_store.sv
`timescale 1ns/1ps
// Summary of operation
// - First power-up with motor: fetch data unprompted
// - Check set complete, then write to nonvolatile
// - No ready permit without valid motor data
// - Motor data is read-only to the user
// - Control source: 0 none,1 local,2 CAN,3 serial
// - Source change at restart; from 0 at once
// - Position-port function 0..2, resets to 0
// - Port function, bit rate apply after restart
// - Start-up mode codes 0,1,2,3,5,6; 4 undefined
// - Local control plus operation enabled starts mode
// - CAN node number 1..127, resets to 127
// - Node number applies at restart or network reset
// - Bit rate only 50/125/250/500/1000, reset 125
module disc_config_store (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic reg_ack,
  output logic reg_err,
  output logic [15:0] reg_rdata,
  output logic nvm_req,
  output logic nvm_we,
  output logic [3:0] nvm_addr,
  output logic [15:0] nvm_wdata,
  input wire logic nvm_ack,
  input wire logic [15:0] nvm_rdata,
  input wire logic motor_present,
  input wire logic sens_toggle,
  input wire logic [15:0] sens_word,
  output logic sens_req,
  input wire logic nmt_reset,
  input wire logic op_enabled,
  output disc_pkg::disc_cfg_t cfg_active,
  output logic ready_permit,
  output logic mode_start,
  output logic [15:0] mode_sel
);

  // ****************************************
  // State
  // ****************************************
  disc_pkg::disc_state_t state_r;
  logic [15:0] pend_r [disc_pkg::NUM_CFG], act_r [disc_pkg::NUM_CFG];
  logic [15:0] motor_r [disc_pkg::MOTOR_WORDS];
  logic [3:0] idx_r, nvm_addr_r;
  logic [15:0] csum_r, seal_r, reg_rdata_r, nvm_wdata_r, mode_sel_r;
  logic motor_valid_r, reg_ack_r, reg_err_r, nvm_req_r, nvm_we_r;
  logic sens_req_r, ready_r, mode_start_r, op_prev_r;
  // Pin synchronisers; stage one feeds stage two only
  logic pres_s1_r, pres_s2_r;
  logic tog_s1_r, tog_s2_r, tog_s3_r;
  logic [15:0] word_s1_r, word_s2_r;

  // ****************************************
  // Value checks
  // ****************************************
  function automatic logic value_ok(input logic [2:0] slot, input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    case (slot)
      disc_pkg::SLOT_CTRL_SRC: ok = (v <= disc_pkg::SRC_SERIAL_FIELDBUS);
      disc_pkg::SLOT_POS_FN: ok = (v <= disc_pkg::POS_FN_MAX);
      disc_pkg::SLOT_START_MODE: ok = (v <= disc_pkg::MODE_SEQUENCED_MOTION) &&
                                      (v != disc_pkg::MODE_UNDEFINED);
      disc_pkg::SLOT_NODE: ok = (v >= disc_pkg::NODE_MIN) && (v <= disc_pkg::NODE_MAX);
      disc_pkg::SLOT_BAUD: ok = v inside {disc_pkg::BAUD_50K, disc_pkg::BAUD_125K,
                                          disc_pkg::BAUD_250K, disc_pkg::BAUD_500K,
                                          disc_pkg::BAUD_1000K};
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : value_ok
  function automatic logic [15:0] reset_value(input logic [2:0] slot);
    logic [15:0] r;
    r = 16'h0000;
    case (slot)
      disc_pkg::SLOT_CTRL_SRC: r = disc_pkg::RST_CTRL_SRC;
      disc_pkg::SLOT_POS_FN: r = disc_pkg::RST_POS_FN;
      disc_pkg::SLOT_START_MODE: r = disc_pkg::RST_START_MODE;
      disc_pkg::SLOT_NODE: r = disc_pkg::RST_NODE;
      disc_pkg::SLOT_BAUD: r = disc_pkg::RST_BAUD;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction : reset_value

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_src = (reg_addr == disc_pkg::OFS_CTRL_SRC);
  wire hit_pos = (reg_addr == disc_pkg::OFS_POS_FN);
  wire hit_mode = (reg_addr == disc_pkg::OFS_START_MODE);
  wire hit_node = (reg_addr == disc_pkg::OFS_NODE);
  wire hit_baud = (reg_addr == disc_pkg::OFS_BAUD);
  wire hit_cfg = hit_src | hit_pos | hit_mode | hit_node | hit_baud;
  wire [2:0] slot = hit_pos ? disc_pkg::SLOT_POS_FN : hit_mode ? disc_pkg::SLOT_START_MODE :
                    hit_node ? disc_pkg::SLOT_NODE :
                    hit_baud ? disc_pkg::SLOT_BAUD : disc_pkg::SLOT_CTRL_SRC;
  wire [15:0] motor_ofs = reg_addr - disc_pkg::OFS_MOTOR_BASE;
  wire hit_motor = (reg_addr >= disc_pkg::OFS_MOTOR_BASE) &&
                   (motor_ofs < 16'(disc_pkg::MOTOR_WORDS));
  wire hit_status = (reg_addr == disc_pkg::OFS_STATUS);
  wire take = reg_req && !reg_ack_r && (state_r == disc_pkg::ST_IDLE);
  wire take_rd = take && !reg_we;
  wire take_wr = take && reg_we && hit_cfg && value_ok(slot, reg_wdata);
  // Motor data set refuses every user write, as do bad values and holes
  wire take_bad = take && reg_we && !(hit_cfg && value_ok(slot, reg_wdata));
  wire [15:0] status_word = {13'h0000, state_r == disc_pkg::ST_IDLE, motor_valid_r, ready_r};
  wire [15:0] rd_word = hit_cfg ? pend_r[slot] : hit_motor ? motor_r[motor_ofs[2:0]] :
                        hit_status ? status_word : 16'h0000;
  wire rd_bad = !(hit_cfg || hit_motor || hit_status);

  // ****************************************
  // Sensor and drive-state events
  // ****************************************
  wire sens_event = tog_s2_r ^ tog_s3_r;
  wire nvm_done = nvm_req_r && nvm_ack;
  wire load_last = (idx_r == disc_pkg::NVM_LAST_LOAD);
  wire fetch_last = (idx_r == 4'(disc_pkg::MOTOR_WORDS));
  wire [3:0] store_ofs = idx_r - disc_pkg::NVM_MOTOR_BASE;
  wire store_last = (store_ofs == 4'(disc_pkg::MOTOR_WORDS - 1));
  wire op_rise = op_enabled && !op_prev_r;
  wire local_io = (act_r[disc_pkg::SLOT_CTRL_SRC] == disc_pkg::SRC_LOCAL_IO);
  wire [15:0] nvm_slot_word = value_ok(idx_r[2:0], nvm_rdata) ? nvm_rdata :
                              reset_value(idx_r[2:0]);

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pres_s1_r <= 1'b0;
      pres_s2_r <= 1'b0;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      word_s1_r <= 16'h0000;
      word_s2_r <= 16'h0000;
    end else if (ce) begin
      pres_s1_r <= motor_present;
      pres_s2_r <= pres_s1_r;
      tog_s1_r <= sens_toggle;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      word_s1_r <= sens_word;
      word_s2_r <= word_s1_r;
    end
  end

  // ****************************************
  // Register answers and drive-side outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
      ready_r <= 1'b0;
      op_prev_r <= 1'b0;
      mode_start_r <= 1'b0;
      mode_sel_r <= disc_pkg::MODE_NONE;
    end else if (ce) begin
      if (take_rd) begin
        reg_rdata_r <= rd_word;
      end
      ready_r <= motor_valid_r;
      op_prev_r <= op_enabled;
      // Mode none leaves the drive idle, so no start pulse for it
      mode_start_r <= op_rise && local_io &&
                      (act_r[disc_pkg::SLOT_START_MODE] != disc_pkg::MODE_NONE);
      if (op_rise && local_io) begin
        mode_sel_r <= act_r[disc_pkg::SLOT_START_MODE];
      end
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= disc_pkg::ST_LOAD;
      idx_r <= 4'h0;
      csum_r <= 16'h0000;
      motor_valid_r <= 1'b0;
      seal_r <= 16'h0000;
      reg_ack_r <= 1'b0;
      reg_err_r <= 1'b0;
      nvm_req_r <= 1'b1;
      nvm_we_r <= 1'b0;
      nvm_addr_r <= 4'h0;
      nvm_wdata_r <= 16'h0000;
      sens_req_r <= 1'b0;
      for (int i = 0; i < disc_pkg::NUM_CFG; i++) begin
        pend_r[i] <= reset_value(3'(i));
        act_r[i] <= reset_value(3'(i));
      end
      for (int i = 0; i < disc_pkg::MOTOR_WORDS; i++) begin
        motor_r[i] <= 16'h0000;
      end
    end else if (ce) begin
      reg_ack_r <= 1'b0;
      reg_err_r <= 1'b0;
      if (nmt_reset) begin
        act_r[disc_pkg::SLOT_NODE] <= pend_r[disc_pkg::SLOT_NODE];
      end
      case (state_r)
        disc_pkg::ST_LOAD: begin
          // Power-up: pending copy read back and made active at once
          if (nvm_done) begin
            if (idx_r < 4'(disc_pkg::NUM_CFG)) begin
              pend_r[idx_r[2:0]] <= nvm_slot_word;
              act_r[idx_r[2:0]] <= nvm_slot_word;
            end
            if (idx_r == disc_pkg::NVM_VALID_SLOT) begin
              seal_r <= nvm_rdata;
            end
            if (idx_r >= disc_pkg::NVM_MOTOR_BASE) begin
              motor_r[store_ofs[2:0]] <= nvm_rdata;
            end
            if (load_last) begin
              nvm_req_r <= 1'b0;
              state_r <= disc_pkg::ST_CHECK;
            end else begin
              idx_r <= idx_r + 4'h1;
              nvm_addr_r <= idx_r + 4'h1;
            end
          end
        end
        disc_pkg::ST_CHECK: begin
          idx_r <= 4'h0;
          if (seal_r == disc_pkg::NVM_SEAL) begin
            motor_valid_r <= 1'b1;
            state_r <= disc_pkg::ST_IDLE;
          end else if (pres_s2_r) begin
            sens_req_r <= 1'b1;
            state_r <= disc_pkg::ST_FETCH;
          end else begin
            state_r <= disc_pkg::ST_IDLE;
          end
        end
        disc_pkg::ST_FETCH: begin
          // Data words, then one checksum word; a bad sum restarts the read
          if (sens_event) begin
            if (fetch_last) begin
              idx_r <= 4'h0;
              csum_r <= 16'h0000;
              if (word_s2_r == csum_r) begin
                sens_req_r <= 1'b0;
                idx_r <= disc_pkg::NVM_MOTOR_BASE;
                nvm_req_r <= 1'b1;
                nvm_we_r <= 1'b1;
                nvm_addr_r <= disc_pkg::NVM_MOTOR_BASE;
                nvm_wdata_r <= motor_r[0];
                state_r <= disc_pkg::ST_STORE;
              end
            end else begin
              motor_r[idx_r[2:0]] <= word_s2_r;
              csum_r <= csum_r + word_s2_r;
              idx_r <= idx_r + 4'h1;
            end
          end
        end
        disc_pkg::ST_STORE: begin
          if (nvm_done) begin
            if (store_last) begin
              nvm_addr_r <= disc_pkg::NVM_VALID_SLOT;
              nvm_wdata_r <= disc_pkg::NVM_SEAL;
              state_r <= disc_pkg::ST_SEAL;
            end else begin
              idx_r <= idx_r + 4'h1;
              nvm_addr_r <= idx_r + 4'h1;
              nvm_wdata_r <= motor_r[3'(store_ofs + 4'h1)];
            end
          end
        end
        disc_pkg::ST_SEAL: begin
          if (nvm_done) begin
            nvm_req_r <= 1'b0;
            nvm_we_r <= 1'b0;
            motor_valid_r <= 1'b1;
            state_r <= disc_pkg::ST_IDLE;
          end
        end
        disc_pkg::ST_IDLE: begin
          if (take_rd || take_bad) begin
            reg_ack_r <= 1'b1;
            reg_err_r <= take_bad || rd_bad;
          end
          if (take_wr) begin
            // Active copy waits for restart, or network reset for node; only leaving undefined is immediate
            pend_r[slot] <= reg_wdata;
            if (hit_src && (act_r[disc_pkg::SLOT_CTRL_SRC] == disc_pkg::SRC_UNDEFINED)) begin
              act_r[disc_pkg::SLOT_CTRL_SRC] <= reg_wdata;
            end
            nvm_req_r <= 1'b1;
            nvm_we_r <= 1'b1;
            nvm_addr_r <= {1'b0, slot};
            nvm_wdata_r <= reg_wdata;
            state_r <= disc_pkg::ST_SAVE;
          end
        end
        disc_pkg::ST_SAVE: begin
          if (nvm_done) begin
            nvm_req_r <= 1'b0;
            nvm_we_r <= 1'b0;
            reg_ack_r <= 1'b1;
            state_r <= disc_pkg::ST_IDLE;
          end
        end
        default: state_r <= disc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_ack = reg_ack_r;
  assign reg_err = reg_err_r;
  assign reg_rdata = reg_rdata_r;
  assign nvm_req = nvm_req_r;
  assign nvm_we = nvm_we_r;
  assign nvm_addr = nvm_addr_r;
  assign nvm_wdata = nvm_wdata_r;
  assign sens_req = sens_req_r;
  assign ready_permit = ready_r;
  assign mode_start = mode_start_r;
  assign mode_sel = mode_sel_r;
  assign cfg_active = {act_r[0], act_r[1], act_r[2], act_r[3], act_r[4]};

endmodule : disc_config_store

// ===== test/disc_nvm_model.sv
`timescale 1ns/1ps
// ****************************************
// Nonvolatile word store on the far side of the block
// ****************************************
module disc_nvm_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire logic [3:0] nvm_addr,
  input wire logic [15:0] nvm_wdata,
  output logic nvm_ack,
  output logic [15:0] nvm_rdata
);
  logic [15:0] mem_r [16];
  logic [1:0] wait_r;
  // Blank cells read as all ones, so every setting loads as invalid
  initial begin
    foreach (mem_r[i]) mem_r[i] = 16'hFFFF;
    wait_r = 2'h0;
    nvm_ack = 1'b0;
    nvm_rdata = 16'h0000;
  end
  // Never reset: contents must survive every restart
  always @(posedge sys_clk) begin
    nvm_ack <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm_req && !nvm_ack) begin
      if (slow && wait_r != 2'h3) begin
        wait_r <= wait_r + 2'h1;
      end else begin
        wait_r <= 2'h0;
        nvm_ack <= 1'b1;
        if (nvm_we) mem_r[nvm_addr] <= nvm_wdata;
        else nvm_rdata <= mem_r[nvm_addr];
      end
    end
  end
endmodule : disc_nvm_model

// ===== test/disc_config_props.sv
`timescale 1ns/1ps
module disc_config_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire logic [3:0] nvm_addr,
  input wire logic nmt_reset,
  input wire logic sens_req,
  input wire logic op_enabled,
  input wire disc_pkg::disc_cfg_t cfg_active,
  input wire logic ready_permit,
  input wire logic mode_start,
  input wire logic [15:0] mode_sel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic wr_ack = reg_ack && reg_req && reg_we;
  wire logic wr_on = reg_req && reg_we;
  property p_err_ack;
    reg_err |-> reg_ack;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("error flag without ack");
  property p_motor_ro;
    wr_ack && reg_addr inside {[16'h3000:16'h3007]} |-> reg_err;
  endproperty
  a_motor_ro: assert property (p_motor_ro) else $error("motor word write taken");
  property p_ctrl_rng;
    wr_ack && reg_addr == 16'h0502 && reg_wdata > 16'h0003 |-> reg_err;
  endproperty
  a_ctrl_rng: assert property (p_ctrl_rng) else $error("bad source accepted");
  property p_ctrl_hold;
    $changed(cfg_active.ctrl_src) |-> $past(cfg_active.ctrl_src) == 16'h0000;
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("source changed early");
  property p_pos_rng;
    wr_ack && reg_addr == 16'h0504 && reg_wdata > 16'h0002 |-> reg_err;
  endproperty
  a_pos_rng: assert property (p_pos_rng) else $error("bad port function accepted");
  property p_pos_hold;
    $changed(cfg_active.pos_fn) || $changed(cfg_active.baud) |-> !$past(wr_on);
  endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("setting applied at write");
  property p_mode_rng;
    wr_ack && reg_addr == 16'h0506 && (reg_wdata == 16'h0004 || reg_wdata > 16'h0006)
      |-> reg_err;
  endproperty
  a_mode_rng: assert property (p_mode_rng) else $error("bad mode accepted");
  property p_mode_go;
    $rose(op_enabled) && cfg_active.ctrl_src == 16'h0001 && cfg_active.start_mode != 16'h0000
      |=> mode_start && mode_sel == $past(cfg_active.start_mode);
  endproperty
  a_mode_go: assert property (p_mode_go) else $error("start-up mode not started");
  property p_mode_src;
    mode_start |-> cfg_active.ctrl_src == 16'h0001;
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("mode start without local");
  property p_node_rng;
    wr_ack && reg_addr == 16'h1704 && (reg_wdata == 16'h0000 || reg_wdata > 16'h007F)
      |-> reg_err;
  endproperty
  a_node_rng: assert property (p_node_rng) else $error("bad node accepted");
  property p_node_hold;
    $changed(cfg_active.node) |-> $past(nmt_reset) || !$past(wr_on);
  endproperty
  a_node_hold: assert property (p_node_hold) else $error("node applied at write");
  property p_baud_rng;
    wr_ack && reg_addr == 16'h1706
      && !(reg_wdata inside {16'h0032, 16'h007D, 16'h00FA, 16'h01F4, 16'h03E8}) |-> reg_err;
  endproperty
  a_baud_rng: assert property (p_baud_rng) else $error("bad bit rate accepted");
  property p_fetch;
    sens_req |-> !ready_permit;
  endproperty
  a_fetch: assert property (p_fetch) else $error("ready while fetching");
  property p_seal;
    nvm_req && nvm_we && nvm_addr == 4'h5 |-> !sens_req;
  endproperty
  a_seal: assert property (p_seal) else $error("sealed before check");
endmodule : disc_config_props

bind disc_config_store disc_config_props i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_we(reg_we),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
  .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nmt_reset(nmt_reset),
  .sens_req(sens_req), .op_enabled(op_enabled), .cfg_active(cfg_active),
  .ready_permit(ready_permit), .mode_start(mode_start), .mode_sel(mode_sel)
);

// ===== test/drive_initial_setup_config_test.sv
`timescale 1ns/1ps
module drive_initial_setup_config_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_req = 1'b0;
  logic reg_we = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic motor_present = 1'b1;
  logic sens_toggle = 1'b0;
  logic [15:0] sens_word = 16'h0000;
  logic nmt_reset = 1'b0;
  logic op_enabled = 1'b0;
  logic nvm_slow = 1'b0;
  logic reg_ack, reg_err, nvm_req, nvm_we, nvm_ack, sens_req, ready_permit, mode_start;
  logic [15:0] reg_rdata, nvm_wdata, nvm_rdata, mode_sel, q, v;
  logic [3:0] nvm_addr;
  logic e;
  disc_pkg::disc_cfg_t cfg_active;
  int bad_count = 0;
  int checks = 0;
  logic [15:0] mw [8];
  logic [15:0] pend [5];
  logic [15:0] ofs [5];
  logic [15:0] probe [16];

  always #5 sys_clk = ~sys_clk;

  disc_config_store i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .reg_rdata(reg_rdata), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata),
    .motor_present(motor_present), .sens_toggle(sens_toggle), .sens_word(sens_word),
    .sens_req(sens_req), .nmt_reset(nmt_reset), .op_enabled(op_enabled),
    .cfg_active(cfg_active), .ready_permit(ready_permit), .mode_start(mode_start),
    .mode_sel(mode_sel)
  );
  disc_nvm_model i_nvm (
    .sys_clk(sys_clk), .slow(nvm_slow), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata)
  );

  function automatic logic ok_val(int s, logic [15:0] x);
    case (s)
      0: return x <= 16'h0003;
      1: return x <= 16'h0002;
      2: return x <= 16'h0006 && x != 16'h0004;
      3: return x >= 16'h0001 && x <= 16'h007F;
      default: return x inside {16'h0032, 16'h007D, 16'h00FA, 16'h01F4, 16'h03E8};
    endcase
  endfunction : ok_val

  task check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic wait_hi(ref logic s, input string nm);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 3000) begin
        check(nm, 80'h0, 80'h1);
        report_and_stop;
      end
    end
  endtask : wait_hi

  // Request is held past the ack edge so the ack cycle still shows it
  task access(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_req = 1'b1;
    reg_we = w;
    reg_addr = a;
    reg_wdata = d;
    wait_hi(reg_ack, "reg_ack");
    q = reg_rdata;
    e = reg_err;
    @(negedge sys_clk);
    reg_req = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access

  task wr(input logic [15:0] a, input logic [15:0] d, input logic xe);
    access(1'b1, a, d);
    check("reg_err", e, xe);
  endtask : wr

  task rd(input logic [15:0] a, input logic [15:0] x, input logic xe);
    access(1'b0, a, 16'h0000);
    check("reg_rdata", q, x);
    check("reg_err", e, xe);
  endtask : rd

  task restart;
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("ready_permit", ready_permit, 1'b0);
    rst_n = 1'b1;
  endtask : restart

  // Word is held four cycles either side of the toggle, then scrambled
  task send_word(input logic [15:0] d);
    sens_word = d;
    repeat (4) @(negedge sys_clk);
    sens_toggle = ~sens_toggle;
    repeat (4) @(negedge sys_clk);
    sens_word = ~d;
    @(negedge sys_clk);
  endtask : send_word

  task send_set(input logic [15:0] add);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      send_word(mw[i]);
      s = s + mw[i];
    end
    send_word(s + add);
  endtask : send_set

  task op_try(input logic go, input logic [15:0] sel);
    logic seen;
    seen = 1'b0;
    @(negedge sys_clk);
    op_enabled = 1'b1;
    repeat (4) begin
      @(negedge sys_clk);
      if (mode_start === 1'b1) begin
        seen = 1'b1;
        v = mode_sel;
      end
    end
    op_enabled = 1'b0;
    check("mode_start", seen, go);
    if (go) check("mode_sel", v, sel);
  endtask : op_try

  initial begin
    ofs = '{16'h0502, 16'h0504, 16'h0506, 16'h1704, 16'h1706};
    pend = '{16'h0000, 16'h0000, 16'h0000, 16'h007F, 16'h007D};
    probe = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
      16'h0007, 16'h0032, 16'h007D, 16'h007F, 16'h0080, 16'h00FA, 16'h01F4, 16'h03E8,
      16'hFFFF};
    v = 16'($urandom(82622));
    restart;
    wait_hi(sens_req, "sens_req");
    check("cfg_active", cfg_active, {pend[0], pend[1], pend[2], pend[3], pend[4]});
    check("ready_permit", ready_permit, 1'b0);
    $display("test power-up defaults done");
    foreach (mw[i]) mw[i] = 16'($urandom);
    send_set(16'h0001);
    repeat (10) @(negedge sys_clk);
    check("sens_req", sens_req, 1'b1);
    check("ready_permit", ready_permit, 1'b0);
    send_set(16'h0000);
    wait_hi(ready_permit, "ready_permit");
    check("nvm seal", i_nvm.mem_r[5], disc_pkg::NVM_SEAL);
    for (int i = 0; i < 8; i++) begin
      check("nvm motor", i_nvm.mem_r[8 + i], mw[i]);
      rd(16'(16'h3000 + i), mw[i], 1'b0);
    end
    wr(16'h3003, ~mw[3], 1'b1);
    rd(16'h3003, mw[3], 1'b0);
    rd(16'h0000, 16'h0000, 1'b1);
    $display("test motor fetch done");
    nvm_slow = 1'b1;
    for (int s = 1; s < 5; s++) begin
      for (int k = 0; k < 17; k++) begin
        v = (k < 16) ? probe[k] : 16'($urandom_range(0, 1100));
        wr(ofs[s], v, !ok_val(s, v));
        if (ok_val(s, v)) pend[s] = v;
        rd(ofs[s], pend[s], 1'b0);
      end
    end
    check("cfg_active", cfg_active[63:0], 64'h0000_0000_007F_007D);
    for (int c = 0; c < 5; c++) wr(ofs[0], 16'(c), c > 3);
    check("ctrl_src", cfg_active.ctrl_src, 16'h0001);
    op_try(1'b0, 16'h0000);
    wr(ofs[3], 16'h0042, 1'b0);
    wr(ofs[2], 16'h0005, 1'b0);
    pend[0] = 16'h0003;
    pend[2] = 16'h0005;
    pend[3] = 16'h0042;
    check("node", cfg_active.node, 16'h007F);
    @(negedge sys_clk);
    ce = 1'b0;
    nmt_reset = 1'b1;
    @(negedge sys_clk);
    // Frozen clock enable must hold off the reset request until ce returns
    check("node", cfg_active.node, 16'h007F);
    ce = 1'b1;
    @(negedge sys_clk);
    nmt_reset = 1'b0;
    @(negedge sys_clk);
    check("node", cfg_active.node, 16'h0042);
    $display("test register writes done");
    restart;
    wait_hi(ready_permit, "ready_permit");
    rd(16'h3010, 16'h0007, 1'b0);
    check("sens_req", sens_req, 1'b0);
    check("cfg_active", cfg_active, {pend[0], pend[1], pend[2], pend[3], pend[4]});
    op_try(1'b0, 16'h0000);
    wr(ofs[0], 16'h0001, 1'b0);
    check("ctrl_src", cfg_active.ctrl_src, 16'h0003);
    nvm_slow = 1'b0;
    restart;
    wait_hi(ready_permit, "ready_permit");
    rd(16'h3010, 16'h0007, 1'b0);
    check("ctrl_src", cfg_active.ctrl_src, 16'h0001);
    op_try(1'b1, 16'h0005);
    $display("test restart done");
    report_and_stop;
  end
endmodule : drive_initial_setup_config_test
